// [src/dtc_top.sv]
// Dual 8/13/16-bit timer/counter with external interrupt flags and
// clock-rate control, on the cpu special-function-register port.
// Assumes a single cpu clock and vectoring strobes from the cpu core.
//
// Summary of operation
// - Edge type: falling edge on irq1 pin sets its flag; vector or software clears.
// - Level type: irq1 flag mirrors low pin; software writes ignored.
// - Irq0 flag behaves as irq1 flag, with its own pin and type bit.
// - Irq1 type bit: 1 selects falling edge, 0 selects low level.
// - Irq0 type bit: 1 selects falling edge, 0 selects low level.
// - Mode 0 counts 13 bits: low five of low byte, all of high.
// - Count only with run set (timer b needs none while timer a is split) and, when gated, irq pin high.
// - Source select picks divided clock or falling edges on count input.
// - 13-bit rollover sets overflow flag and one-cycle overflow pulse.
// - Mode 1 counts 16 bits, rolling to zero after all ones.
// - Mode 2: low byte counts, reloads from high byte past 0xFF.
// - Timer b in mode 3 stops and holds its count.
// - Timer a mode 3: low byte counts with timer a's own controls.
// - Timer a mode 3: high byte counts clock, run b, flag b.
// - With timer a split, timer b runs in modes 0-2, stops in 3.
// - Rate bit 1 gives increment every four clocks, 0 every twelve.
// - Rate bits do not affect counting of external transitions.
// - Stretch field gives two plus value cycles; register resets to 0x01.
// - Overflow flags set on overflow (timer b's not while timer a is split), cleared on vectoring.
// - Mode bits: 00 13-bit, 01 16-bit, 10 reload, 11 split.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_top
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Special-function-register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Vectoring strobes from the cpu
	input  wire logic       vec_ext0,
	input  wire logic       vec_ext1,
	input  wire logic       vec_ctr_a,
	input  wire logic       vec_ctr_b,
	// Pins
	input  wire logic       ext_irq0_pin_n,
	input  wire logic       ext_irq1_pin_n,
	input  wire logic       ctr_a_ext_in,
	input  wire logic       ctr_b_ext_in,
	// Flags and pulses
	output logic            ext0_edge_flag,
	output logic            ext1_edge_flag,
	output logic            ctr_a_ovf_flag,
	output logic            ctr_b_ovf_flag,
	output logic            ctr_a_ovf_pulse,
	output logic            ctr_b_ovf_pulse,
	// Clock-control fields used elsewhere
	output logic      [2:0] ext_mem_stretch,
	output logic            ctr_c_fast_sel
);
	import dtc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	dtc_core_s   r;
	dtc_core_s   n;
	dtc_mode_e   mode_a;
	dtc_mode_e   mode_b;
	logic        split_a;
	logic [16:0] step_a;
	logic [16:0] step_b;
	logic        src_a;
	logic        src_b;
	logic        en_a;
	logic        en_ah;
	logic        en_b;
	logic        ovf_a;
	logic        ovf_ah;
	logic        ovf_b;
	logic        wr_tctl;
	logic        wr_a;
	logic        wr_b;

	dtc_io_if io ();

	// ------------------------------------------------------------------
	// Prescaler and pin synchroniser
	// ------------------------------------------------------------------
	dtc_prescale u_pre
	(
		.mclk (mclk),
		.rstn (rstn),
		.io   (io)
	);

	dtc_sync u_sync
	(
		.mclk (mclk),
		.rstn (rstn),
		.pins ({ctr_b_ext_in, ctr_a_ext_in, ext_irq1_pin_n, ext_irq0_pin_n}),
		.io   (io)
	);

	// ------------------------------------------------------------------
	// Count enables
	// ------------------------------------------------------------------
	// Mode fields decode straight into the enum
	assign mode_a  = dtc_mode_e'(r.tmode[1:0]);
	assign mode_b  = dtc_mode_e'(r.tmode[5:4]);
	assign split_a = (mode_a == DTC_SPLIT);

	// External edges bypass the rate bits
	assign src_a = r.tmode[`DTC_CT0] ? io.fall[`DTC_PIN_TA] :
		(r.ckctl[`DTC_A_FAST] ? io.tick4 : io.tick12);
	assign src_b = r.tmode[`DTC_CT1] ? io.fall[`DTC_PIN_TB] :
		(r.ckctl[`DTC_B_FAST] ? io.tick4 : io.tick12);

	// Gate uses the synchronised pin level, high means counting allowed
	assign en_a = r.tctl[`DTC_A_RUN] & src_a
		& (~r.tmode[`DTC_GATE0] | io.lvl[`DTC_PIN_IRQ0]);
	// Split high byte: clock only, run bit borrowed from timer b
	assign en_ah = split_a & r.tctl[`DTC_B_RUN]
		& (r.ckctl[`DTC_A_FAST] ? io.tick4 : io.tick12);
	// With timer a split, timer b's own run bit is taken; mode 3 turns it off
	assign en_b = (mode_b != DTC_SPLIT) & (split_a | r.tctl[`DTC_B_RUN])
		& src_b & (~r.tmode[`DTC_GATE1] | io.lvl[`DTC_PIN_IRQ1]);

	assign step_a = dtc_step(mode_a, r.a_low, r.a_high);
	assign step_b = dtc_step(mode_b, r.b_low, r.b_high);

	assign ovf_a  = en_a & step_a[16];
	assign ovf_ah = en_ah & (r.a_high == 8'hFF);
	assign ovf_b  = en_b & step_b[16];

	// Register write strobes, from direct address compares
	assign wr_tctl = sfr_wr & (sfr_addr == `DTC_ADR_TCTL);
	assign wr_a    = sfr_wr & ((sfr_addr == `DTC_ADR_A_LOW) | (sfr_addr == `DTC_ADR_A_HIGH));
	assign wr_b    = sfr_wr & ((sfr_addr == `DTC_ADR_B_LOW) | (sfr_addr == `DTC_ADR_B_HIGH));

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.pulse_a = ovf_a;
		n.pulse_b = ovf_b | ovf_ah;
		// Counting; low byte upper bits in mode 0 are left as they were
		if (en_a)
		begin
			n.a_low = step_a[7:0];
			if (!split_a)
				n.a_high = step_a[15:8];
		end
		if (en_ah)
			n.a_high = r.a_high + 8'h01;
		if (en_b)
		begin
			n.b_low  = step_b[7:0];
			n.b_high = step_b[15:8];
		end
		// Software writes win over a same-cycle increment
		if (sfr_wr)
		begin
			if (sfr_addr == `DTC_ADR_TCTL)
				n.tctl = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_TMODE)
				n.tmode = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_A_LOW)
				n.a_low = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_B_LOW)
				n.b_low = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_A_HIGH)
				n.a_high = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_B_HIGH)
				n.b_high = sfr_wdata;
			else if (sfr_addr == `DTC_ADR_CKCTL)
				n.ckctl = sfr_wdata & `DTC_CKCTL_WMASK;
		end
		// Vectoring clears, then hardware sets so a same-cycle event survives
		if (vec_ctr_a)
			n.tctl[`DTC_A_OVF] = 1'b0;
		if (vec_ctr_b)
			n.tctl[`DTC_B_OVF] = 1'b0;
		if (ovf_a)
			n.tctl[`DTC_A_OVF] = 1'b1;
		if ((ovf_b & !split_a) | ovf_ah)
			n.tctl[`DTC_B_OVF] = 1'b1;
		// External interrupt 1
		if (n.tctl[`DTC_X1_TYPE])
		begin
			if (vec_ext1)
				n.tctl[`DTC_X1_FLAG] = 1'b0;
			if (io.fall[`DTC_PIN_IRQ1])
				n.tctl[`DTC_X1_FLAG] = 1'b1;
		end
		else
			n.tctl[`DTC_X1_FLAG] = ~io.lvl[`DTC_PIN_IRQ1];
		// External interrupt 0
		if (n.tctl[`DTC_X0_TYPE])
		begin
			if (vec_ext0)
				n.tctl[`DTC_X0_FLAG] = 1'b0;
			if (io.fall[`DTC_PIN_IRQ0])
				n.tctl[`DTC_X0_FLAG] = 1'b1;
		end
		else
			n.tctl[`DTC_X0_FLAG] = ~io.lvl[`DTC_PIN_IRQ0];
		// Read data is captured on the read strobe and then held
		if (sfr_rd)
		begin
			if (sfr_addr == `DTC_ADR_TCTL)
				n.rdata = r.tctl;
			else if (sfr_addr == `DTC_ADR_TMODE)
				n.rdata = r.tmode;
			else if (sfr_addr == `DTC_ADR_A_LOW)
				n.rdata = r.a_low;
			else if (sfr_addr == `DTC_ADR_B_LOW)
				n.rdata = r.b_low;
			else if (sfr_addr == `DTC_ADR_A_HIGH)
				n.rdata = r.a_high;
			else if (sfr_addr == `DTC_ADR_B_HIGH)
				n.rdata = r.b_high;
			else if (sfr_addr == `DTC_ADR_CKCTL)
				n.rdata = r.ckctl;
			else
				n.rdata = 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			r       <= '0;
			r.tctl  <= `DTC_TCTL_RST;
			r.tmode <= `DTC_TMODE_RST;
			r.ckctl <= `DTC_CKCTL_RST;
		end
		else
			r <= n;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign sfr_rdata       = r.rdata;
	assign ext0_edge_flag  = r.tctl[`DTC_X0_FLAG];
	assign ext1_edge_flag  = r.tctl[`DTC_X1_FLAG];
	assign ctr_a_ovf_flag  = r.tctl[`DTC_A_OVF];
	assign ctr_b_ovf_flag  = r.tctl[`DTC_B_OVF];
	assign ctr_a_ovf_pulse = r.pulse_a;
	assign ctr_b_ovf_pulse = r.pulse_b;
	assign ext_mem_stretch = r.ckctl[2:0];
	assign ctr_c_fast_sel  = r.ckctl[`DTC_C_FAST];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	AST_EXT1_EDGE_SET: assert property (
		(r.tctl[`DTC_X1_TYPE] && !wr_tctl && io.fall[`DTC_PIN_IRQ1]) |=> ext1_edge_flag)
		else $error("edge on irq1 did not set its flag");
	AST_EXT1_LEVEL: assert property (
		(!r.tctl[`DTC_X1_TYPE] && !wr_tctl)
		|=> (ext1_edge_flag == !$past(io.lvl[`DTC_PIN_IRQ1])))
		else $error("irq1 flag does not follow pin in level mode");
	AST_EXT0_EDGE_SET: assert property (
		(r.tctl[`DTC_X0_TYPE] && !wr_tctl && io.fall[`DTC_PIN_IRQ0]) |=> ext0_edge_flag)
		else $error("edge on irq0 did not set its flag");
	AST_EXT1_NO_LEVEL_SET: assert property (
		(r.tctl[`DTC_X1_TYPE] && !wr_tctl && !ext1_edge_flag && !io.fall[`DTC_PIN_IRQ1])
		|=> !ext1_edge_flag)
		else $error("irq1 flag set without an edge in edge mode");
	AST_EXT0_LEVEL: assert property (
		(!r.tctl[`DTC_X0_TYPE] && !wr_tctl)
		|=> (ext0_edge_flag == !$past(io.lvl[`DTC_PIN_IRQ0])))
		else $error("irq0 flag does not follow pin in level mode");
	AST_M13_ROLL: assert property (
		(en_a && mode_a == DTC_M13 && {r.a_high, r.a_low[4:0]} == 13'h1FFF && !wr_a)
		|=> (ctr_a_ovf_pulse && ctr_a_ovf_flag && r.a_high == 8'h00 && r.a_low[4:0] == 5'h00)
		##1 !ctr_a_ovf_pulse)
		else $error("13-bit rollover wrong");
	AST_RELOAD: assert property (
		(en_a && mode_a == DTC_M8R && r.a_low == 8'hFF && !wr_a) |=> (r.a_low == $past(r.a_high)))
		else $error("mode 2 reload missing");
	AST_B_HOLD: assert property (
		(mode_b == DTC_SPLIT && !wr_b) |=> ($stable(r.b_low) && $stable(r.b_high)))
		else $error("timer b counted in mode 3");
	AST_GATE_HOLD: assert property (
		(r.tmode[`DTC_GATE0] && !io.lvl[`DTC_PIN_IRQ0] && !split_a && !wr_a)
		|=> ($stable(r.a_low) && $stable(r.a_high)))
		else $error("gated timer a counted with pin low");
	AST_STRETCH_RST: assert property (
		$rose(rstn) |-> (ext_mem_stretch == 3'h1 && !ctr_c_fast_sel))
		else $error("clock control reset value wrong");

	COV_M13_ROLL: cover property (ovf_a && mode_a == DTC_M13);
	COV_RELOAD:   cover property (ovf_a && mode_a == DTC_M8R);
	COV_SPLIT_HI: cover property (ovf_ah);
	COV_EXT_EDGE: cover property (r.tctl[`DTC_X1_TYPE] && io.fall[`DTC_PIN_IRQ1]);
endmodule

`default_nettype wire

// [src/dtc_params.svh]
// Constants of the dual timer/counter block: register addresses, bit
// positions, reset values and prescaler counts.
// Assumes it is included by bare name from every file that needs it.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register addresses in the special-function space
// ----------------------------------------------------------------------
`define DTC_ADR_TCTL     8'h88
`define DTC_ADR_TMODE    8'h89
`define DTC_ADR_A_LOW    8'h8A
`define DTC_ADR_B_LOW    8'h8B
`define DTC_ADR_A_HIGH   8'h8C
`define DTC_ADR_B_HIGH   8'h8D
`define DTC_ADR_CKCTL    8'h8E

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define DTC_B_OVF        7
`define DTC_B_RUN        6
`define DTC_A_OVF        5
`define DTC_A_RUN        4
`define DTC_X1_FLAG      3
`define DTC_X1_TYPE      2
`define DTC_X0_FLAG      1
`define DTC_X0_TYPE      0
`define DTC_GATE1        7
`define DTC_CT1          6
`define DTC_GATE0        3
`define DTC_CT0          2
`define DTC_C_FAST       5
`define DTC_B_FAST       4
`define DTC_A_FAST       3
`define DTC_PIN_IRQ0     0
`define DTC_PIN_IRQ1     1
`define DTC_PIN_TA       2
`define DTC_PIN_TB       3

// ----------------------------------------------------------------------
// Reset values, masks and prescaler counts
// ----------------------------------------------------------------------
`define DTC_TCTL_RST     8'h00
`define DTC_TMODE_RST    8'h00
`define DTC_CKCTL_RST    8'h01
`define DTC_CKCTL_WMASK  8'h3F
`define DTC_PRE_LAST     4'hB
`define DTC_PRE_FAST     2'h3
`define DTC_SYNC_RST     4'hF

`endif

// [src/dtc_pkg.sv]
// Types and shared arithmetic of the dual timer/counter block.
// Assumes dtc_params.svh is on the include path.
`include "dtc_params.svh"

package dtc_pkg;

	// Mode-select decode of a timer's two mode bits
	typedef enum logic [1:0] {
		DTC_M13   = 2'b00,
		DTC_M16   = 2'b01,
		DTC_M8R   = 2'b10,
		DTC_SPLIT = 2'b11
	} dtc_mode_e;

	typedef struct packed {
		logic [7:0] tctl;
		logic [7:0] tmode;
		logic [7:0] ckctl;
		logic [7:0] a_low;
		logic [7:0] a_high;
		logic [7:0] b_low;
		logic [7:0] b_high;
		logic [7:0] rdata;
		logic       pulse_a;
		logic       pulse_b;
	} dtc_core_s;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
	} dtc_sync_s;

	typedef struct packed {
		logic [3:0] cnt;
	} dtc_pre_s;

	// One increment of a timer; returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input dtc_mode_e m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [15:0] c16;
		c13 = {hi, lo[4:0]} + 13'h0001;
		c16 = {hi, lo} + 16'h0001;
		case (m)
			DTC_M13: dtc_step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5], lo[7:5], c13[4:0]};
			DTC_M16: dtc_step = {({hi, lo} == 16'hFFFF), c16};
			DTC_M8R: dtc_step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, c16[7:0]};
			default: dtc_step = {(lo == 8'hFF), hi, c16[7:0]};
		endcase
	endfunction

endpackage

// [src/dtc_io_if.sv]
// Carrier between the prescaler, the pin synchroniser and the timer core.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface dtc_io_if;
	logic       tick4;
	logic       tick12;
	logic [3:0] lvl;
	logic [3:0] fall;

	modport pre  (output tick4, output tick12);
	modport syn  (output lvl, output fall);
	modport core (input tick4, input tick12, input lvl, input fall);
endinterface

`default_nettype wire

// [src/dtc_prescale.sv]
// Divide-by-4 and divide-by-12 enable pulses from the cpu clock.
// Assumes one free-running clock; both ticks are one cycle wide.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_prescale
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// Tick outputs
	dtc_io_if.pre     io
);
	dtc_pre_s r;
	dtc_pre_s n;

	// Modulo-12 count; 12 is a multiple of 4 so both ticks share it
	always_comb
	begin
		n = r;
		n.cnt = (r.cnt == `DTC_PRE_LAST) ? 4'h0 : r.cnt + 4'h1;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			r <= '0;
		else
			r <= n;
	end

	assign io.tick12 = (r.cnt == `DTC_PRE_LAST);
	assign io.tick4  = (r.cnt[1:0] == `DTC_PRE_FAST);

	AST_TICK12_SPACING: assert property (@(posedge mclk) disable iff (!rstn)
		io.tick12 |=> (!io.tick12)[*8] ##1 (!io.tick12)[*3] ##1 io.tick12)
		else $error("slow tick not every twelve cycles");
	AST_TICK4_SPACING: assert property (@(posedge mclk) disable iff (!rstn)
		io.tick4 |=> (!io.tick4)[*3] ##1 io.tick4)
		else $error("fast tick not every four cycles");
endmodule

`default_nettype wire

// [src/dtc_sync.sv]
// Two-stage synchroniser and falling-edge detector for the four pins.
// Assumes pins idle high; edges are found on the synchronised copy.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_sync
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Raw pins
	input  wire logic [3:0] pins,
	// Synchronised levels and edges
	dtc_io_if.syn           io
);
	dtc_sync_s r;
	dtc_sync_s n;

	// Shift chain; s1 feeds s2 only, s3 is the previous sample
	always_comb
	begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			r <= {`DTC_SYNC_RST, `DTC_SYNC_RST, `DTC_SYNC_RST};
		else
			r <= n;
	end

	assign io.lvl  = r.s2;
	assign io.fall = r.s3 & ~r.s2;
endmodule

`default_nettype wire

// [dv/dtc_pins_model.sv]
// Far-side model: the two interrupt pins and the two count inputs.
// Assumes the bench calls its tasks; all four lines idle high.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dtc_pins_model
(
	// Clock
	input  wire logic       mclk,
	// Pins towards the block
	output logic      [3:0] pins
);
	logic [3:0] lvl = `DTC_SYNC_RST;

	// Lines are always driven, so no stale level can leak
	assign pins = lvl;

	// One pin changes just after an edge
	task automatic set_pin(input int i, input logic v);
		@(posedge mclk);
		#1 lvl[i] = v;
	endtask

	// Falling edges; each level held two cycles for the synchroniser
	task automatic pulse(input int i, input int n);
		repeat (n)
		begin
			set_pin(i, 1'b0);
			@(posedge mclk);
			set_pin(i, 1'b1);
			@(posedge mclk);
		end
	endtask
endmodule

`default_nettype wire

// [dv/dual_timer_counter_ext_irq_tb_top.sv]
// Self-checking bench for the dual timer/counter block.
// Assumes dtc_top and the pin model; registers reached by sfr strobes.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"

module dual_timer_counter_ext_irq_tb_top;
	logic       mclk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [3:0] vec = 4'h0;
	logic [3:0] pins;
	logic [1:0] eflag;
	logic [1:0] oflag;
	logic [1:0] opulse;
	logic [2:0] stretch;
	logic       c_fast;
	int         fail_count = 0;
	int         checked = 0;

	// ------------------------------------------------------------
	// Design and far side
	// ------------------------------------------------------------
	dtc_top dut (.mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .vec_ext0(vec[0]), .vec_ext1(vec[1]),
		.vec_ctr_a(vec[2]), .vec_ctr_b(vec[3]),
		.ext_irq0_pin_n(pins[`DTC_PIN_IRQ0]),
		.ext_irq1_pin_n(pins[`DTC_PIN_IRQ1]),
		.ctr_a_ext_in(pins[`DTC_PIN_TA]), .ctr_b_ext_in(pins[`DTC_PIN_TB]),
		.ext0_edge_flag(eflag[0]), .ext1_edge_flag(eflag[1]),
		.ctr_a_ovf_flag(oflag[0]), .ctr_b_ovf_flag(oflag[1]),
		.ctr_a_ovf_pulse(opulse[0]), .ctr_b_ovf_pulse(opulse[1]),
		.ext_mem_stretch(stretch), .ctr_c_fast_sel(c_fast));

	dtc_pins_model pm (.mclk(mclk), .pins(pins));

	// 10 MHz clock
	always #50 mclk = ~mclk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
			fail_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge mclk);
		#1 sfr_wr = 1'b0;
	endtask

	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1 sfr_rd = 1'b1;
		sfr_addr = a;
		@(posedge mclk);
		#1 sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	task automatic vpulse(input int i);
		@(posedge mclk);
		#1 vec[i] = 1'b1;
		@(posedge mclk);
		#1 vec[i] = 1'b0;
	endtask

	// Counts edges up to and including the next overflow pulse
	task automatic wait_pulse(input int w, output int n);
		for (n = 1; n <= 300; n++)
		begin
			@(posedge mclk);
			#1;
			if (opulse[w] === 1'b1)
				return;
		end
		// Ran out of cycles: counted as a mismatch on the pulse
		chk(8'(opulse[w]), 8'h01);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_regs();
		logic [7:0] d;
		rd(`DTC_ADR_CKCTL, d);
		chk(d, 8'h01);
		chk(8'(stretch), 8'h01);
		rd(`DTC_ADR_TCTL, d);
		chk(d, 8'h00);
		wr(8'h80, 8'h5A);
		rd(8'h80, d);
		chk(d, 8'h00);
		wr(`DTC_ADR_CKCTL, 8'hFF);
		rd(`DTC_ADR_CKCTL, d);
		chk(d, 8'h3F);
		chk({c_fast, 4'h0, stretch}, 8'h87);
	endtask

	// Edge and level type for one interrupt line
	task automatic t_ext(input int i);
		wr(`DTC_ADR_TCTL, 8'(1 << (2 * i)));
		pm.pulse(i, 1);
		repeat (3) @(posedge mclk);
		#1 chk(8'(eflag[i]), 8'h01);
		vpulse(i);
		chk(8'(eflag[i]), 8'h00);
		pm.pulse(i, 1);
		repeat (3) @(posedge mclk);
		#1 chk(8'(eflag[i]), 8'h01);
		wr(`DTC_ADR_TCTL, 8'(1 << (2 * i)));
		chk(8'(eflag[i]), 8'h00);
		wr(`DTC_ADR_TCTL, 8'h00);
		pm.set_pin(i, 1'b0);
		repeat (4) @(posedge mclk);
		#1 chk(8'(eflag[i]), 8'h01);
		// Vectoring has no effect on a level-type flag
		vpulse(i);
		chk(8'(eflag[i]), 8'h01);
		pm.set_pin(i, 1'b1);
		wr(`DTC_ADR_TCTL, 8'(1 << (2 * i + 1)));
		repeat (4) @(posedge mclk);
		#1 chk(8'(eflag[i]), 8'h00);
	endtask

	// Rollover from all ones in modes 0 and 1
	task automatic t_roll();
		logic [7:0] d;
		int         n;
		for (int m = 0; m < 2; m++)
		begin
			wr(`DTC_ADR_TCTL, 8'h00);
			wr(`DTC_ADR_CKCTL, 8'h01);
			wr(`DTC_ADR_TMODE, 8'(m));
			wr(`DTC_ADR_A_LOW, 8'hFF);
			wr(`DTC_ADR_A_HIGH, 8'hFF);
			wr(`DTC_ADR_TCTL, 8'h10);
			wait_pulse(0, n);
			chk(8'(oflag[0]), 8'h01);
			vpulse(2);
			chk(8'({opulse[0], oflag[0]}), 8'h00);
			wr(`DTC_ADR_TCTL, 8'h00);
			rd(`DTC_ADR_A_HIGH, d);
			chk(d, 8'h00);
			rd(`DTC_ADR_A_LOW, d);
			chk(d & (m == 1 ? 8'hFF : 8'h1F), 8'h00);
		end
	endtask

	// Reload every second tick: interval gives the tick rate
	task automatic t_reload_rate();
		logic [7:0] d;
		int         n;
		wr(`DTC_ADR_TMODE, 8'h02);
		wr(`DTC_ADR_A_LOW, 8'hFE);
		wr(`DTC_ADR_A_HIGH, 8'hFE);
		wr(`DTC_ADR_CKCTL, 8'h09);
		wr(`DTC_ADR_TCTL, 8'h10);
		wait_pulse(0, n);
		wait_pulse(0, n);
		chk(8'(n), 8'h08);
		wr(`DTC_ADR_CKCTL, 8'h01);
		wait_pulse(0, n);
		wait_pulse(0, n);
		chk(8'(n), 8'h18);
		wr(`DTC_ADR_TCTL, 8'h00);
		rd(`DTC_ADR_A_LOW, d);
		chk(d, 8'hFE);
	endtask

	// Gate, then external count source with the fast rate set
	task automatic t_gate_count();
		logic [7:0] d;
		wr(`DTC_ADR_TMODE, 8'h09);
		wr(`DTC_ADR_A_LOW, 8'h00);
		wr(`DTC_ADR_CKCTL, 8'h09);
		pm.set_pin(0, 1'b0);
		wr(`DTC_ADR_TCTL, 8'h10);
		repeat (40) @(posedge mclk);
		rd(`DTC_ADR_A_LOW, d);
		chk(d, 8'h00);
		pm.set_pin(0, 1'b1);
		repeat (40) @(posedge mclk);
		rd(`DTC_ADR_A_LOW, d);
		chk(8'(d != 8'h00), 8'h01);
		wr(`DTC_ADR_TCTL, 8'h00);
		wr(`DTC_ADR_TMODE, 8'h05);
		wr(`DTC_ADR_A_LOW, 8'h00);
		wr(`DTC_ADR_TCTL, 8'h10);
		pm.pulse(`DTC_PIN_TA, 5);
		rd(`DTC_ADR_A_LOW, d);
		chk(d, 8'h05);
	endtask

	// Timer a split: high byte on run b and flag b; timer b held
	task automatic t_split();
		logic [7:0] d;
		int         n;
		wr(`DTC_ADR_TCTL, 8'h00);
		wr(`DTC_ADR_TMODE, 8'h33);
		wr(`DTC_ADR_B_LOW, 8'h55);
		wr(`DTC_ADR_A_HIGH, 8'hFE);
		wr(`DTC_ADR_TCTL, 8'h40);
		wait_pulse(1, n);
		chk(8'(oflag[1]), 8'h01);
		vpulse(3);
		chk(8'(oflag[1]), 8'h00);
		rd(`DTC_ADR_B_LOW, d);
		chk(d, 8'h55);
		wr(`DTC_ADR_TCTL, 8'h00);
		wr(`DTC_ADR_TMODE, 8'h13);
		repeat (30) @(posedge mclk);
		rd(`DTC_ADR_B_LOW, d);
		chk(8'(d != 8'h55), 8'h01);
		// Timer b keeps its own source select while timer a is split
		wr(`DTC_ADR_TMODE, 8'h53);
		wr(`DTC_ADR_B_LOW, 8'h10);
		pm.pulse(`DTC_PIN_TB, 3);
		rd(`DTC_ADR_B_LOW, d);
		chk(d, 8'h13);
	endtask

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// About 500 cycles expected; ten thousand is ample
	initial
	begin
		#1_000_000;
		fail_count++;
		end_of_test();
	end

	initial
	begin
		repeat (2) @(posedge mclk);
		#1 rstn = 1'b1;
		t_reset_regs();
		t_ext(0);
		t_ext(1);
		t_roll();
		t_reload_rate();
		t_gate_count();
		t_split();
		end_of_test();
	end
endmodule

`default_nettype wire
